//--- rtl/pfm_pkg.sv
// Constants and state type for the pin function multiplexer
package pfm_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ROUTE_SEL_OFS = 8'h00;
    localparam logic [7:0] ROUTE_STAT_OFS = 8'h04;
    localparam logic [7:0] STRAP_STAT_OFS = 8'h08;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // Select bit positions in the route select register
    // ------------------------------------------------------------
    localparam int SEL_W = 12;
    localparam int SEL_HOST_IO0 = 0;
    localparam int SEL_PWR_DOWN = 1;
    localparam int SEL_HOST_IO2 = 2;
    localparam int SEL_CLK_RUN = 3;
    localparam int SEL_HOST_IO4 = 4;
    localparam int SEL_TIMER_B = 5;
    localparam int SEL_HOST_IO3 = 6;
    localparam int SEL_KEY17 = 7;
    localparam int SEL_SMB2 = 8;
    localparam int SEL_KBM2 = 9;
    localparam int SEL_TEST = 10;
    localparam int SEL_SERIAL = 11;
    localparam logic [SEL_W-1:0] SEL_RST = 12'h000;

    // ------------------------------------------------------------
    // Pin indices and route codes
    // ------------------------------------------------------------
    localparam int NP = 15;
    localparam int P10 = 0;
    localparam int P11 = 1;
    localparam int P14 = 2;
    localparam int P57 = 3;
    localparam int P61 = 4;
    localparam int P62 = 5;
    localparam int P26 = 6;
    localparam int P27 = 7;
    localparam int P83 = 8;
    localparam int P42 = 9;
    localparam int P43 = 10;
    localparam int P44 = 11;
    localparam int P46 = 12;
    localparam int P50 = 13;
    localparam int P52 = 14;
    localparam logic [1:0] ROUTE_DEF = 2'h0;
    localparam logic [1:0] ROUTE_ALT1 = 2'h1;
    localparam logic [1:0] ROUTE_ALT2 = 2'h2;
    localparam logic [1:0] ROUTE_ALT3 = 2'h3;
    localparam logic [NP-1:0] PIN_IDLE = 15'h00F1;
    localparam logic [4*NP-1:0] FIN_RST = 60'h0000000FFFF000F;
    localparam logic [2*NP-1:0] ROUTE_RST = 30'h00030000;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef struct packed {
        logic [SEL_W-1:0] sel;
        logic wr_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [NP-1:0] s1;
        logic [NP-1:0] s2;
        logic [NP-1:0] pin_out;
        logic [NP-1:0] pin_oe;
        logic [4*NP-1:0] fin;
        logic [2*NP-1:0] route;
        logic strap_done;
        logic [1:0] strap_cnt;
        logic strap_val;
    } pfm_state_s;

    localparam pfm_state_s STATE_RST = '{
        sel: SEL_RST, wr_pend: 1'b0, addr: 8'h00, rdata: 32'h0000_0000,
        s1: 15'h0000, s2: 15'h0000, pin_out: 15'h0000, pin_oe: 15'h0000,
        fin: FIN_RST, route: ROUTE_RST, strap_done: 1'b0, strap_cnt: 2'h0,
        strap_val: 1'b0};

endpackage

//--- rtl/pfm_pin_mux.sv
// Pin function multiplexer with AHB-Lite route select registers
//
// Local design decisions: the AHB-Lite slave port and the register offsets.

// Overview of operation
// - A higher alternate column's select wins over all lower ones.
// - No select set for a pin: pin carries its general-purpose signal; pin eight_three does so only once the strap is sampled.
// - Pin one_zero: host io zero, or power-down input which wins.
// - Pin one_one: host io two, or clock run which wins.
// - Pin one_four: host io four, or timer input B which wins.
// - Pin five_seven: host io three, or key scan drive 17 which wins.
// - One select moves both SMBus channel two pins together.
// - One select moves both keyboard-mouse channel two pins together.
// - Test port select puts the test port on its pin group, top priority.
// - Pin eight_three: serial transmit, or base address strap input on top.
module pfm_pin_mux
    import pfm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NP-1:0] gpio_out,
    input wire logic [NP-1:0] gpio_oe,
    output logic [NP-1:0] gpio_in,
    input wire logic pin_io_one_zero_in,
    output logic pin_io_one_zero_out,
    output logic pin_io_one_zero_oe,
    input wire logic pin_io_one_one_in,
    output logic pin_io_one_one_out,
    output logic pin_io_one_one_oe,
    input wire logic pin_io_one_four_in,
    output logic pin_io_one_four_out,
    output logic pin_io_one_four_oe,
    input wire logic pin_io_five_seven_in,
    output logic pin_io_five_seven_out,
    output logic pin_io_five_seven_oe,
    input wire logic pin_io_six_one_in,
    output logic pin_io_six_one_out,
    output logic pin_io_six_one_oe,
    input wire logic pin_io_six_two_in,
    output logic pin_io_six_two_out,
    output logic pin_io_six_two_oe,
    input wire logic pin_io_two_six_in,
    output logic pin_io_two_six_out,
    output logic pin_io_two_six_oe,
    input wire logic pin_io_two_seven_in,
    output logic pin_io_two_seven_out,
    output logic pin_io_two_seven_oe,
    input wire logic pin_out_eight_three_in,
    output logic pin_out_eight_three_out,
    output logic pin_out_eight_three_oe,
    input wire logic pin_io_four_two_in,
    output logic pin_io_four_two_out,
    output logic pin_io_four_two_oe,
    input wire logic pin_io_four_three_in,
    output logic pin_io_four_three_out,
    output logic pin_io_four_three_oe,
    input wire logic pin_io_four_four_in,
    output logic pin_io_four_four_out,
    output logic pin_io_four_four_oe,
    input wire logic pin_io_four_six_in,
    output logic pin_io_four_six_out,
    output logic pin_io_four_six_oe,
    input wire logic pin_io_five_zero_in,
    output logic pin_io_five_zero_out,
    output logic pin_io_five_zero_oe,
    input wire logic pin_io_five_two_in,
    output logic pin_io_five_two_out,
    output logic pin_io_five_two_oe,
    input wire logic host_pin_io_zero_out,
    input wire logic host_pin_io_zero_oe,
    output logic host_pin_io_zero_in,
    input wire logic host_pin_io_two_out,
    input wire logic host_pin_io_two_oe,
    output logic host_pin_io_two_in,
    input wire logic host_pin_io_four_out,
    input wire logic host_pin_io_four_oe,
    output logic host_pin_io_four_in,
    input wire logic host_pin_io_three_out,
    input wire logic host_pin_io_three_oe,
    output logic host_pin_io_three_in,
    output logic bus_power_down_in,
    input wire logic clock_run_pull,
    output logic clock_run_in,
    output logic timer1_pin_b,
    input wire logic key_scan_drive_17,
    input wire logic smbus_ch2_clock_pin_low,
    output logic smbus_ch2_clock_pin_in,
    input wire logic smbus_ch2_data_pin_low,
    output logic smbus_ch2_data_pin_in,
    input wire logic kbm_ch2_clock_pin_out,
    input wire logic kbm_ch2_clock_pin_oe,
    output logic kbm_ch2_clock_pin_in,
    input wire logic kbm_ch2_data_pin_out,
    input wire logic kbm_ch2_data_pin_oe,
    output logic kbm_ch2_data_pin_in,
    output logic test_clock_in,
    output logic test_mode_in,
    output logic test_data_in,
    output logic test_reset_n_in,
    input wire logic test_data_out,
    input wire logic test_ready_out,
    input wire logic serial_tx_pin,
    output logic base_addr_strap_1,
    output logic strap_valid
);

    pfm_state_s st;
    pfm_state_s n;
    logic [NP-1:0] pin_in_v;
    logic [3:0] src_out [NP];
    logic [3:0] src_oe [NP];

    // ------------------------------------------------------------
    // Pin bundling
    // ------------------------------------------------------------
    assign pin_in_v = {pin_io_five_two_in, pin_io_five_zero_in, pin_io_four_six_in,
        pin_io_four_four_in, pin_io_four_three_in, pin_io_four_two_in,
        pin_out_eight_three_in, pin_io_two_seven_in, pin_io_two_six_in,
        pin_io_six_two_in, pin_io_six_one_in, pin_io_five_seven_in,
        pin_io_one_four_in, pin_io_one_one_in, pin_io_one_zero_in};
    assign {pin_io_five_two_out, pin_io_five_zero_out, pin_io_four_six_out,
        pin_io_four_four_out, pin_io_four_three_out, pin_io_four_two_out,
        pin_out_eight_three_out, pin_io_two_seven_out, pin_io_two_six_out,
        pin_io_six_two_out, pin_io_six_one_out, pin_io_five_seven_out,
        pin_io_one_four_out, pin_io_one_one_out, pin_io_one_zero_out} = st.pin_out;
    assign {pin_io_five_two_oe, pin_io_five_zero_oe, pin_io_four_six_oe,
        pin_io_four_four_oe, pin_io_four_three_oe, pin_io_four_two_oe,
        pin_out_eight_three_oe, pin_io_two_seven_oe, pin_io_two_six_oe,
        pin_io_six_two_oe, pin_io_six_one_oe, pin_io_five_seven_oe,
        pin_io_one_four_oe, pin_io_one_one_oe, pin_io_one_zero_oe} = st.pin_oe;

    // ------------------------------------------------------------
    // Drive sources per pin, columns {alt3, alt2, alt1, default}
    // ------------------------------------------------------------
    assign src_out[P10] = {1'b0, 1'b0, host_pin_io_zero_out, gpio_out[P10]};
    assign src_oe[P10] = {1'b0, 1'b0, host_pin_io_zero_oe, gpio_oe[P10]};
    assign src_out[P11] = {1'b0, 1'b0, host_pin_io_two_out, gpio_out[P11]};
    assign src_oe[P11] = {1'b0, clock_run_pull, host_pin_io_two_oe, gpio_oe[P11]};
    assign src_out[P14] = {1'b0, 1'b0, host_pin_io_four_out, gpio_out[P14]};
    assign src_oe[P14] = {1'b0, 1'b0, host_pin_io_four_oe, gpio_oe[P14]};
    assign src_out[P57] = {1'b0, 1'b0, host_pin_io_three_out, gpio_out[P57]};
    assign src_oe[P57] = {1'b0, ~key_scan_drive_17, host_pin_io_three_oe, gpio_oe[P57]};
    assign src_out[P61] = {1'b0, 1'b0, 1'b0, gpio_out[P61]};
    assign src_oe[P61] = {1'b0, 1'b0, smbus_ch2_clock_pin_low, gpio_oe[P61]};
    assign src_out[P62] = {1'b0, 1'b0, 1'b0, gpio_out[P62]};
    assign src_oe[P62] = {1'b0, 1'b0, smbus_ch2_data_pin_low, gpio_oe[P62]};
    assign src_out[P26] = {1'b0, 1'b0, kbm_ch2_clock_pin_out, gpio_out[P26]};
    assign src_oe[P26] = {1'b0, 1'b0, kbm_ch2_clock_pin_oe, gpio_oe[P26]};
    assign src_out[P27] = {1'b0, 1'b0, kbm_ch2_data_pin_out, gpio_out[P27]};
    assign src_oe[P27] = {1'b0, 1'b0, kbm_ch2_data_pin_oe, gpio_oe[P27]};
    assign src_out[P83] = {1'b0, 1'b0, serial_tx_pin, gpio_out[P83]};
    assign src_oe[P83] = {1'b0, 1'b0, 1'b1, gpio_oe[P83]};
    assign src_out[P50] = {test_data_out, 1'b0, 1'b0, gpio_out[P50]};
    assign src_oe[P50] = {1'b1, 1'b0, 1'b0, gpio_oe[P50]};
    assign src_out[P52] = {test_ready_out, 1'b0, 1'b0, gpio_out[P52]};
    assign src_oe[P52] = {1'b1, 1'b0, 1'b0, gpio_oe[P52]};

    // Test port inputs: pins only listen in the test column
    for (genvar g = P42; g <= P46; g++) begin : g_test_in
        assign src_out[g] = {1'b0, 1'b0, 1'b0, gpio_out[g]};
        assign src_oe[g] = {1'b0, 1'b0, 1'b0, gpio_oe[g]};
    end

    // ------------------------------------------------------------
    // Function side inputs, idle level when not routed; gpio_in always follows the synchronised pin
    // ------------------------------------------------------------
    assign gpio_in = st.s2;
    assign host_pin_io_zero_in = st.fin[P10*4+1];
    assign bus_power_down_in = st.fin[P10*4+2];
    assign host_pin_io_two_in = st.fin[P11*4+1];
    assign clock_run_in = st.fin[P11*4+2];
    assign host_pin_io_four_in = st.fin[P14*4+1];
    assign timer1_pin_b = st.fin[P14*4+2];
    assign host_pin_io_three_in = st.fin[P57*4+1];
    assign smbus_ch2_clock_pin_in = st.fin[P61*4+1];
    assign smbus_ch2_data_pin_in = st.fin[P62*4+1];
    assign kbm_ch2_clock_pin_in = st.fin[P26*4+1];
    assign kbm_ch2_data_pin_in = st.fin[P27*4+1];
    assign test_clock_in = st.fin[P42*4+3];
    assign test_mode_in = st.fin[P43*4+3];
    assign test_data_in = st.fin[P44*4+3];
    assign test_reset_n_in = st.fin[P46*4+3];
    assign base_addr_strap_1 = st.strap_val;
    assign strap_valid = st.strap_done;

    // ------------------------------------------------------------
    // Bus slave outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = st;
        n.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            n.wr_pend = hwrite && (hsize == HSIZE_WORD);
            n.addr = haddr[7:0];
            case (haddr[7:0])
                ROUTE_SEL_OFS: n.rdata = {{(32-SEL_W){1'b0}}, st.sel};
                ROUTE_STAT_OFS: n.rdata = {2'h0, st.route};
                STRAP_STAT_OFS: n.rdata = {30'h0000_0000, st.strap_done, st.strap_val};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        if (st.wr_pend && st.addr == ROUTE_SEL_OFS) begin
            n.sel = hwdata[SEL_W-1:0];
        end
        // Pin synchronisers
        n.s1 = pin_in_v;
        n.s2 = st.s1;
        // Strap is sampled once the synchroniser has settled
        if (!st.strap_done) begin
            if (st.strap_cnt == STRAP_SETTLE) begin
                n.strap_val = st.s2[P83];
                n.strap_done = 1'b1;
            end else begin
                n.strap_cnt = st.strap_cnt + 2'h1;
            end
        end
        // Route decode, highest column checked first
        n.route = '0;
        n.route[2*P10 +: 2] = st.sel[SEL_PWR_DOWN] ? ROUTE_ALT2 :
            (st.sel[SEL_HOST_IO0] ? ROUTE_ALT1 : ROUTE_DEF);
        n.route[2*P11 +: 2] = st.sel[SEL_CLK_RUN] ? ROUTE_ALT2 :
            (st.sel[SEL_HOST_IO2] ? ROUTE_ALT1 : ROUTE_DEF);
        n.route[2*P14 +: 2] = st.sel[SEL_TIMER_B] ? ROUTE_ALT2 :
            (st.sel[SEL_HOST_IO4] ? ROUTE_ALT1 : ROUTE_DEF);
        n.route[2*P57 +: 2] = st.sel[SEL_KEY17] ? ROUTE_ALT2 :
            (st.sel[SEL_HOST_IO3] ? ROUTE_ALT1 : ROUTE_DEF);
        n.route[2*P61 +: 2] = st.sel[SEL_SMB2] ? ROUTE_ALT1 : ROUTE_DEF;
        n.route[2*P62 +: 2] = st.sel[SEL_SMB2] ? ROUTE_ALT1 : ROUTE_DEF;
        n.route[2*P26 +: 2] = st.sel[SEL_KBM2] ? ROUTE_ALT1 : ROUTE_DEF;
        n.route[2*P27 +: 2] = st.sel[SEL_KBM2] ? ROUTE_ALT1 : ROUTE_DEF;
        n.route[2*P83 +: 2] = !n.strap_done ? ROUTE_ALT3 :
            (st.sel[SEL_SERIAL] ? ROUTE_ALT1 : ROUTE_DEF);
        for (int p = P42; p <= P52; p++) begin
            n.route[2*p +: 2] = st.sel[SEL_TEST] ? ROUTE_ALT3 : ROUTE_DEF;
        end
        // Pin drive and function input fan-out per current route
        for (int p = 0; p < NP; p++) begin
            n.pin_out[p] = src_out[p][st.route[2*p +: 2]];
            n.pin_oe[p] = src_oe[p][st.route[2*p +: 2]];
            for (int r = 0; r < 4; r++) begin
                n.fin[p*4+r] = (int'(st.route[2*p +: 2]) == r) ? st.s2[p] : PIN_IDLE[p];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= STATE_RST;
        end else begin
            st <= n;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sel_reset_a: assert property ((!st.strap_done && st.strap_cnt == 2'h0) |->
        (st.sel == SEL_RST && st.route[2*P10 +: 2] == ROUTE_DEF))
        else $error("select bits not clear after reset");
    default_route_a: assert property ((st.sel == '0 && st.strap_done) |=>
        (st.route == '0))
        else $error("pin left default with no select set");
    pd_priority_a: assert property ((st.sel[SEL_PWR_DOWN] && st.sel[SEL_HOST_IO0]) |=>
        (st.route[2*P10 +: 2] == ROUTE_ALT2) ##1 (!pin_io_one_zero_oe))
        else $error("power-down column lost priority");
    clk_run_a: assert property ((st.sel[SEL_CLK_RUN] ##1 st.sel[SEL_CLK_RUN]) |=>
        (pin_io_one_one_oe == $past(clock_run_pull)))
        else $error("clock run not routed");
    timer_route_a: assert property (st.sel[SEL_TIMER_B] |=>
        (st.route[2*P14 +: 2] == ROUTE_ALT2))
        else $error("timer input not routed");
    key_drive_a: assert property ((st.sel[SEL_KEY17] ##1 st.sel[SEL_KEY17]) |=>
        (pin_io_five_seven_oe == !$past(key_scan_drive_17) && !pin_io_five_seven_out))
        else $error("key scan drive not routed");
    smbus_pair_a: assert property ((st.sel[SEL_SMB2] ##1 st.sel[SEL_SMB2]) |=>
        (pin_io_six_one_oe == $past(smbus_ch2_clock_pin_low)
        && pin_io_six_two_oe == $past(smbus_ch2_data_pin_low)))
        else $error("smbus pair not switched together");
    kbm_pair_a: assert property ($changed(st.sel[SEL_KBM2]) |=>
        (st.route[2*P26 +: 2] == st.route[2*P27 +: 2]
        && st.route[2*P27 +: 2] == {1'b0, $past(st.sel[SEL_KBM2])}))
        else $error("keyboard-mouse pair split");
    test_port_a: assert property (st.sel[SEL_TEST] |=>
        (st.route[2*P44 +: 2] == ROUTE_ALT3) ##1 pin_io_five_zero_oe)
        else $error("test port not on top column");
    serial_tx_a: assert property ((st.sel[SEL_SERIAL] && st.strap_done ##1
        st.sel[SEL_SERIAL]) |=> (pin_out_eight_three_oe
        && pin_out_eight_three_out == $past(serial_tx_pin)))
        else $error("serial transmit not on pin");
    pd_in_a: assert property ((st.route[2*P10 +: 2] == ROUTE_ALT2) |=>
        (bus_power_down_in == $past(st.s2[P10])))
        else $error("pd input lost");
    pd_idle_a: assert property ((st.route[2*P10 +: 2] != ROUTE_ALT2) |=>
        bus_power_down_in)
        else $error("pd input not idle");
    clk_run_in_a: assert property ((st.route[2*P11 +: 2] == ROUTE_ALT2) |=>
        (clock_run_in == $past(st.s2[P11])))
        else $error("clock run input lost");
    timer_in_a: assert property ((st.route[2*P14 +: 2] == ROUTE_ALT2) |=>
        (timer1_pin_b == $past(st.s2[P14])))
        else $error("timer input lost");
    smbus_in_a: assert property ((st.route[2*P61 +: 2] == ROUTE_ALT1) |=>
        (smbus_ch2_clock_pin_in == $past(st.s2[P61])))
        else $error("smbus input lost");
    kbm_drive_a: assert property ((st.route[2*P26 +: 2] == ROUTE_ALT1) |=>
        (pin_io_two_six_oe == $past(kbm_ch2_clock_pin_oe)
        && pin_io_two_six_out == $past(kbm_ch2_clock_pin_out)))
        else $error("kbm clock not driven");
    test_in_a: assert property ((st.route[2*P42 +: 2] == ROUTE_ALT3) |=>
        (test_clock_in == $past(st.s2[P42]) && test_reset_n_in == $past(st.s2[P46])))
        else $error("test inputs lost");
    strap_col_a: assert property (!st.strap_done |->
        !pin_out_eight_three_oe)
        else $error("strap pin driven");
    gpio_drive_a: assert property ((st.route[2*P61 +: 2] == ROUTE_DEF) |=>
        (pin_io_six_one_oe == $past(gpio_oe[P61])
        && pin_io_six_one_out == $past(gpio_out[P61])))
        else $error("gpio drive lost");

endmodule

//--- sim/pfm_board_model.sv
// Board model that settles each shared pin from the device drive and board sources
module pfm_board_model
    import pfm_pkg::*;
(
    input wire logic [NP-1:0] dev_out,
    input wire logic [NP-1:0] dev_oe,
    input wire logic [NP-1:0] board_lvl,
    output logic [NP-1:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Device drive wins over the board source
    assign pin_lvl = (dev_oe & dev_out) | (~dev_oe & board_lvl);
endmodule

//--- sim/pin_function_mux_bench.sv
// Self-checking bench for the pin function multiplexer
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module pin_function_mux_bench
    import pfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans, smb_lo, smb_in, kbm_out, kbm_oe, kbm_in;
    logic [2:0] hsize;
    logic [3:0] h_o, h_e, h_i, tst;
    logic [NP-1:0] gpio_out, gpio_oe, gpio_in, po, pe, pi, board;
    logic pd_in, crun_pull, crun_in, tmr_b, key17, tdo, trdy, ser_tx, strap, strap_ok;
    logic [7:0] fin;
    logic [SEL_W-1:0] s;
    localparam logic [11:0] PAIRS [4] = '{12'h003, 12'h00C, 12'h030, 12'h0C0};
    int error_cnt = 0;
    int comparisons = 0;
    assign fin = {pd_in, tmr_b, tst, smb_in};

    pfm_board_model board_i (.dev_out(po), .dev_oe(pe), .board_lvl(board), .pin_lvl(pi));
    pfm_pin_mux dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .pin_io_one_zero_in(pi[0]), .pin_io_one_zero_out(po[0]), .pin_io_one_zero_oe(pe[0]),
        .pin_io_one_one_in(pi[1]), .pin_io_one_one_out(po[1]), .pin_io_one_one_oe(pe[1]),
        .pin_io_one_four_in(pi[2]), .pin_io_one_four_out(po[2]), .pin_io_one_four_oe(pe[2]),
        .pin_io_five_seven_in(pi[3]), .pin_io_five_seven_out(po[3]),
        .pin_io_five_seven_oe(pe[3]),
        .pin_io_six_one_in(pi[4]), .pin_io_six_one_out(po[4]), .pin_io_six_one_oe(pe[4]),
        .pin_io_six_two_in(pi[5]), .pin_io_six_two_out(po[5]), .pin_io_six_two_oe(pe[5]),
        .pin_io_two_six_in(pi[6]), .pin_io_two_six_out(po[6]), .pin_io_two_six_oe(pe[6]),
        .pin_io_two_seven_in(pi[7]), .pin_io_two_seven_out(po[7]),
        .pin_io_two_seven_oe(pe[7]),
        .pin_out_eight_three_in(pi[8]), .pin_out_eight_three_out(po[8]),
        .pin_out_eight_three_oe(pe[8]),
        .pin_io_four_two_in(pi[9]), .pin_io_four_two_out(po[9]), .pin_io_four_two_oe(pe[9]),
        .pin_io_four_three_in(pi[10]), .pin_io_four_three_out(po[10]),
        .pin_io_four_three_oe(pe[10]),
        .pin_io_four_four_in(pi[11]), .pin_io_four_four_out(po[11]),
        .pin_io_four_four_oe(pe[11]),
        .pin_io_four_six_in(pi[12]), .pin_io_four_six_out(po[12]), .pin_io_four_six_oe(pe[12]),
        .pin_io_five_zero_in(pi[13]), .pin_io_five_zero_out(po[13]),
        .pin_io_five_zero_oe(pe[13]),
        .pin_io_five_two_in(pi[14]), .pin_io_five_two_out(po[14]), .pin_io_five_two_oe(pe[14]),
        .host_pin_io_zero_out(h_o[0]), .host_pin_io_zero_oe(h_e[0]),
        .host_pin_io_zero_in(h_i[0]),
        .host_pin_io_two_out(h_o[1]), .host_pin_io_two_oe(h_e[1]), .host_pin_io_two_in(h_i[1]),
        .host_pin_io_four_out(h_o[2]), .host_pin_io_four_oe(h_e[2]),
        .host_pin_io_four_in(h_i[2]),
        .host_pin_io_three_out(h_o[3]), .host_pin_io_three_oe(h_e[3]),
        .host_pin_io_three_in(h_i[3]),
        .bus_power_down_in(pd_in), .clock_run_pull(crun_pull), .clock_run_in(crun_in),
        .timer1_pin_b(tmr_b), .key_scan_drive_17(key17),
        .smbus_ch2_clock_pin_low(smb_lo[1]), .smbus_ch2_clock_pin_in(smb_in[1]),
        .smbus_ch2_data_pin_low(smb_lo[0]), .smbus_ch2_data_pin_in(smb_in[0]),
        .kbm_ch2_clock_pin_out(kbm_out[1]), .kbm_ch2_clock_pin_oe(kbm_oe[1]),
        .kbm_ch2_clock_pin_in(kbm_in[1]), .kbm_ch2_data_pin_out(kbm_out[0]),
        .kbm_ch2_data_pin_oe(kbm_oe[0]), .kbm_ch2_data_pin_in(kbm_in[0]),
        .test_clock_in(tst[3]), .test_mode_in(tst[2]), .test_data_in(tst[1]),
        .test_reset_n_in(tst[0]), .test_data_out(tdo), .test_ready_out(trdy),
        .serial_tx_pin(ser_tx), .base_addr_strap_1(strap), .strap_valid(strap_ok)
    );

    // ------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (hreadyout !== 1'h1) begin
            error_cnt++;
            print_verdict();
        end
    endtask

    task automatic wait_strap();
        int n;
        n = 0;
        while (strap_ok !== 1'h1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        if (strap_ok !== 1'h1) begin
            error_cnt++;
            print_verdict();
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdv = hrdata;
        `CHK("hresp", 1'h0, hresp)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'h0, a, 32'h00000000);
        `CHK(nm, e, rdv)
    endtask

    task automatic set_sel(input logic [SEL_W-1:0] v);
        xfer(1'h1, ROUTE_SEL_OFS, {20'h00000, v});
        repeat (8) @(posedge hclk);
    endtask

    function automatic logic [2*NP-1:0] exp_route(input logic [SEL_W-1:0] v);
        logic [2*NP-1:0] r;
        r = '0;
        r[2*P10+:2] = v[SEL_PWR_DOWN] ? ROUTE_ALT2 : v[SEL_HOST_IO0] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P11+:2] = v[SEL_CLK_RUN] ? ROUTE_ALT2 : v[SEL_HOST_IO2] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P14+:2] = v[SEL_TIMER_B] ? ROUTE_ALT2 : v[SEL_HOST_IO4] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P57+:2] = v[SEL_KEY17] ? ROUTE_ALT2 : v[SEL_HOST_IO3] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P61+:2] = v[SEL_SMB2] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P62+:2] = v[SEL_SMB2] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P26+:2] = v[SEL_KBM2] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P27+:2] = v[SEL_KBM2] ? ROUTE_ALT1 : ROUTE_DEF;
        r[2*P83+:2] = v[SEL_SERIAL] ? ROUTE_ALT1 : ROUTE_DEF;
        for (int p = P42; p <= P52; p++) begin
            r[2*p+:2] = v[SEL_TEST] ? ROUTE_ALT3 : ROUTE_DEF;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        hresetn = 1'h0;
        {hsel, haddr, htrans, hwrite, hsize, hwdata, gpio_out, gpio_oe} = '0;
        {h_o, h_e, crun_pull, smb_lo, kbm_out, kbm_oe, tdo, trdy, ser_tx} = '0;
        key17 = 1'h1;
        board = 15'h1F04;
        repeat (10) @(posedge hclk);
        `CHK("oe_rst", 15'h0000, pe)
        hresetn <= 1'h1;
        wait_strap();
        rd_chk(STRAP_STAT_OFS, 32'h00000003, "strap");
        `CHK("strap_pin", 2'h3, {strap_ok, strap})
        rd_chk(ROUTE_SEL_OFS, 32'h00000000, "sel_rst");
        rd_chk(ROUTE_STAT_OFS, 32'h00000000, "stat_rst");
        rd_chk(8'h0C, 32'h00000000, "unmapped");
        gpio_oe <= 15'h7FFF;
        gpio_out <= 15'h5A5A;
        repeat (8) @(posedge hclk);
        `CHK("def_out", 15'h5A5A, po)
        `CHK("def_oe", 15'h7FFF, pe)
        `CHK("def_fn", 8'h83, fin)
        `CHK("gpio_in", 15'h5A5A, gpio_in)
        `CHK("crun_idle", 1'h0, crun_in)
        for (int i = 0; i <= SEL_W + 4; i++) begin
            s = (i < SEL_W) ? 12'h001 << i : (i < SEL_W + 4) ? PAIRS[i-SEL_W] : 12'hFFF;
            set_sel(s);
            rd_chk(ROUTE_SEL_OFS, {20'h00000, s}, "sel");
            rd_chk(ROUTE_STAT_OFS, {2'h0, exp_route(s)}, "route");
        end
        h_o <= 4'hF;
        h_e <= 4'hF;
        gpio_out <= 15'h0000;
        set_sel(12'h055);
        `CHK("host_pins", 12'hFFF, {pe[3:0], po[3:0], h_i})
        crun_pull <= 1'h1;
        key17 <= 1'h0;
        smb_lo <= 2'h3;
        kbm_oe <= 2'h3;
        ser_tx <= 1'h1;
        {tdo, trdy} <= 2'h3;
        kbm_out <= 2'h1;
        set_sel(12'hFFF);
        `CHK("alt_oe", 15'h61FA, pe)
        `CHK("alt_out", 15'h6180, po & pe)
        `CHK("alt_fn", 8'h7C, fin)
        `CHK("kbm_in", 2'h1, kbm_in)
        board <= 15'h1E04;
        hresetn <= 1'h0;
        repeat (3) @(posedge hclk);
        `CHK("oe_rst2", 15'h0000, pe)
        hresetn <= 1'h1;
        wait_strap();
        rd_chk(ROUTE_SEL_OFS, 32'h00000000, "sel_rst2");
        rd_chk(STRAP_STAT_OFS, 32'h00000002, "strap2");
        `CHK("strap_pin2", 2'h2, {strap_ok, strap})
        print_verdict();
    end
endmodule
